// ### rtl/fcs_pkg.sv
// Package with command codes, unlock addresses and timing constants for the flash host
`default_nettype none
package fcs_pkg;
  localparam logic [7:0]  CMD_RESET     = 8'hF0;
  localparam logic [7:0]  CMD_UNLOCK1   = 8'hAA;
  localparam logic [7:0]  CMD_UNLOCK2   = 8'h55;
  localparam logic [7:0]  CMD_AUTOSEL   = 8'h90;
  localparam logic [7:0]  CMD_PROGRAM   = 8'hA0;
  localparam logic [7:0]  CMD_ERASE_SET = 8'h80;
  localparam logic [7:0]  CMD_CHIP_ERS  = 8'h10;
  localparam logic [7:0]  CMD_SECT_ERS  = 8'h30;
  localparam logic [14:0] ADDR_UNLOCK1  = 15'h5555;
  localparam logic [14:0] ADDR_UNLOCK2  = 15'h2AAA;
  localparam logic [7:0]  ASEL_MFR      = 8'h00;
  localparam logic [7:0]  ASEL_DEV      = 8'h01;
  localparam logic [7:0]  ASEL_PROT     = 8'h02;
  localparam int          SECT_LSB      = 14;
  localparam int          CLK_MHZ       = 125;
  // Bus cycle phase lengths, in clock cycles
  localparam int          SETUP_CYC     = 2;
  localparam int          STROBE_CYC    = 6;
  localparam int          HOLD_CYC      = 2;
  localparam int          READ_CYC      = 12;
  // Sector accumulation window, in ns; host keeps gaps well inside it
  localparam int          SECT_WIN_NS   = 50000;
  localparam int          SECT_GAP_NS   = 20000;
  localparam int          SECT_GAP_CYC  = (SECT_GAP_NS * CLK_MHZ) / 1000;
  localparam logic [3:0]  OP_READ       = 4'h0;
  localparam logic [3:0]  OP_RESET      = 4'h1;
  localparam logic [3:0]  OP_AUTOSEL    = 4'h2;
  localparam logic [3:0]  OP_PROGRAM    = 4'h3;
  localparam logic [3:0]  OP_CHIP_ERS   = 4'h4;
  localparam logic [3:0]  OP_SECT_ERS   = 4'h5;
  localparam logic [3:0]  OP_SECT_ADD   = 4'h6;
endpackage : fcs_pkg
`default_nettype wire

// ### rtl/fcs_host.sv
// Host controller that issues command sequences and reads on a parallel flash bus
`default_nettype none
module fcs_host (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // Command port
  input  wire logic        i_req,
  input  wire logic [3:0]  i_op,
  input  wire logic [16:0] i_addr,
  input  wire logic [7:0]  i_data,
  output logic             o_busy,
  output logic             o_done,
  output logic [7:0]       o_rdata,
  // Flash pins
  output logic [16:0]      o_fa,
  output logic [7:0]       o_dq_out,
  output logic             o_dq_oe,
  input  wire logic [7:0]  i_dq_in,
  output logic             o_ce_n,
  output logic             o_we_n,
  output logic             o_oe_n
);
  typedef enum logic [2:0] {
    FCS_IDLE  = 3'b000,
    FCS_SETUP = 3'b001,
    FCS_STRB  = 3'b011,
    FCS_HOLD  = 3'b010,
    FCS_GAP   = 3'b110,
    FCS_READ  = 3'b111
  } fcs_state_t;

  localparam int CNT_W = $clog2(fcs_pkg::SECT_GAP_CYC + 1);
  if (fcs_pkg::SECT_GAP_NS >= fcs_pkg::SECT_WIN_NS) begin : g_gap_chk
    $error("Sector gap must stay below the accumulation window");
  end

  fcs_state_t  state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [2:0]  step, next_step;
  logic [2:0]  last, next_last;
  logic [16:0] addr, next_addr;
  logic [7:0]  data, next_data;
  logic [16:0] fa, next_fa;
  logic [7:0]  dq, next_dq;
  logic        dq_oe, next_dq_oe;
  logic        ce_n, next_ce_n, we_n, next_we_n, oe_n, next_oe_n;
  logic        busy, next_busy, done, next_done;
  logic [7:0]  rdata, next_rdata;
  logic        is_read;
  logic [3:0]  op, next_op;

  // Cycle table: unlock and command cycles leave bits 16 and 15 low, except the sector erase cycle, which carries the sector address
  function automatic logic [24:0] cyc(input logic [3:0] o, input logic [2:0] s,
                                      input logic [16:0] a, input logic [7:0] d);
    logic [16:0] ua1;
    logic [16:0] ua2;
    ua1 = {2'b00, fcs_pkg::ADDR_UNLOCK1};
    ua2 = {2'b00, fcs_pkg::ADDR_UNLOCK2};
    cyc = {ua1, fcs_pkg::CMD_RESET};
    unique case (s)
      3'd0: cyc = {ua1, fcs_pkg::CMD_UNLOCK1};
      3'd1: cyc = {ua2, fcs_pkg::CMD_UNLOCK2};
      3'd2: cyc = {ua1, (o == fcs_pkg::OP_AUTOSEL) ? fcs_pkg::CMD_AUTOSEL :
                        (o == fcs_pkg::OP_PROGRAM) ? fcs_pkg::CMD_PROGRAM :
                        fcs_pkg::CMD_ERASE_SET};
      3'd3: cyc = (o == fcs_pkg::OP_PROGRAM) ? {a, d} : {ua1, fcs_pkg::CMD_UNLOCK1};
      3'd4: cyc = {ua2, fcs_pkg::CMD_UNLOCK2};
      3'd5: cyc = (o == fcs_pkg::OP_SECT_ERS) ? {a[16:fcs_pkg::SECT_LSB], 14'h0000,
                                                   fcs_pkg::CMD_SECT_ERS}
                                               : {ua1, fcs_pkg::CMD_CHIP_ERS};
      default: cyc = {ua1, fcs_pkg::CMD_RESET};
    endcase
  endfunction : cyc

  assign is_read = (op == fcs_pkg::OP_READ);

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_step  = step;
    next_last  = last;
    next_addr  = addr;
    next_data  = data;
    next_fa    = fa;
    next_dq    = dq;
    next_dq_oe = dq_oe;
    next_ce_n  = ce_n;
    next_we_n  = we_n;
    next_oe_n  = oe_n;
    next_busy  = busy;
    next_done  = 1'b0;
    next_rdata = rdata;
    next_op    = op;
    unique case (state)
      FCS_IDLE: begin
        if (i_req) begin
          next_op   = i_op;
          next_addr = i_addr;
          next_data = i_data;
          next_busy = 1'b1;
          next_cnt  = '0;
          // Sequence lengths; reset also recovers auto-select and errors
          unique case (i_op)
            fcs_pkg::OP_RESET:    next_last = 3'd0;
            fcs_pkg::OP_AUTOSEL:  next_last = 3'd2;
            fcs_pkg::OP_PROGRAM:  next_last = 3'd3;
            fcs_pkg::OP_SECT_ADD: next_last = 3'd5;
            default:              next_last = 3'd5;
          endcase
          next_step = (i_op == fcs_pkg::OP_SECT_ADD) ? 3'd5 : 3'd0;
          if (i_op == fcs_pkg::OP_READ) begin
            next_fa   = i_addr; // Status or data, device decides
            next_ce_n = 1'b0;
            next_oe_n = 1'b0;
            next_dq_oe = 1'b1;
            next_state = FCS_READ;
          end else begin
            next_state = FCS_SETUP;
          end
        end
      end
      FCS_SETUP: begin
        // Address settles while output enable is high
        {next_fa, next_dq} = (op == fcs_pkg::OP_RESET) ? {17'h0_0000, fcs_pkg::CMD_RESET}
                           : (op == fcs_pkg::OP_SECT_ADD) ? cyc(fcs_pkg::OP_SECT_ERS, step, addr, data)
                           : cyc(op, step, addr, data);
        next_dq_oe = 1'b0;
        next_oe_n  = 1'b1;
        // Chip select leads the strobe so the later falling edge is never ambiguous
        next_ce_n  = 1'b0;
        next_cnt   = cnt + 1'b1;
        if (cnt == CNT_W'(fcs_pkg::SETUP_CYC - 1)) begin
          next_cnt   = '0;
          next_we_n  = 1'b0; // Address taken here
          next_state = FCS_STRB;
        end
      end
      FCS_STRB: begin
        next_cnt = cnt + 1'b1;
        if (cnt == CNT_W'(fcs_pkg::STROBE_CYC - 1)) begin
          next_cnt   = '0;
          next_we_n  = 1'b1; // Data taken on this rising edge
          next_state = FCS_HOLD;
        end
      end
      FCS_HOLD: begin
        next_cnt = cnt + 1'b1;
        if (cnt == CNT_W'(fcs_pkg::HOLD_CYC - 1)) begin
          next_cnt   = '0;
          next_ce_n  = 1'b1;
          next_dq_oe = 1'b1;
          if (step == last) begin
            // Program and erase need no host control after the last write
            next_busy  = 1'b0;
            next_done  = 1'b1;
            next_state = (op == fcs_pkg::OP_SECT_ERS || op == fcs_pkg::OP_SECT_ADD)
                         ? FCS_GAP : FCS_IDLE;
          end else begin
            next_step  = step + 3'd1;
            next_state = FCS_SETUP;
          end
        end
      end
      FCS_GAP: begin
        // Any request ends the safe gap early; otherwise it lasts SECT_GAP_CYC cycles
        next_cnt = cnt + 1'b1;
        if (i_req) begin
          next_state = FCS_IDLE;
        end
        if (cnt == CNT_W'(fcs_pkg::SECT_GAP_CYC - 1)) begin
          next_cnt   = '0;
          next_state = FCS_IDLE;
        end
      end
      FCS_READ: begin
        next_cnt = cnt + 1'b1;
        if (cnt == CNT_W'(fcs_pkg::READ_CYC - 1)) begin
          next_cnt   = '0;
          next_rdata = i_dq_in;
          next_ce_n  = 1'b1;
          next_oe_n  = 1'b1;
          next_busy  = 1'b0;
          next_done  = 1'b1;
          next_state = FCS_IDLE;
        end
      end
      default: next_state = FCS_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= FCS_IDLE;
      cnt   <= '0;
      step  <= 3'd0;
      last  <= 3'd0;
      addr  <= 17'h0_0000;
      data  <= 8'h00;
      fa    <= 17'h0_0000;
      dq    <= 8'h00;
      dq_oe <= 1'b1;
      ce_n  <= 1'b1;
      we_n  <= 1'b1;
      oe_n  <= 1'b1;
      busy  <= 1'b0;
      done  <= 1'b0;
      rdata <= 8'h00;
      op    <= 4'h0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      step  <= next_step;
      last  <= next_last;
      addr  <= next_addr;
      data  <= next_data;
      fa    <= next_fa;
      dq    <= next_dq;
      dq_oe <= next_dq_oe;
      ce_n  <= next_ce_n;
      we_n  <= next_we_n;
      oe_n  <= next_oe_n;
      busy  <= next_busy;
      done  <= next_done;
      rdata <= next_rdata;
      op    <= next_op;
    end
  end

  assign o_busy   = busy;
  assign o_done   = done;
  assign o_rdata  = rdata;
  assign o_fa     = fa;
  assign o_dq_out = dq;
  assign o_dq_oe  = dq_oe;
  assign o_ce_n   = ce_n;
  assign o_we_n   = we_n;
  assign o_oe_n   = oe_n;

  // Write strobe never low with output enable low
  a_write_inhibit_oe: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !we_n |-> (oe_n && !ce_n)) else $error("write strobe with output enable low");
  a_data_driven_strobe: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !we_n |-> !dq_oe) else $error("data not driven during write");
  a_addr_stable_strb: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (!we_n && $past(!we_n)) |-> $stable(fa) && $stable(dq))
    else $error("address or data moved during strobe");
  a_strobe_width: assert property (@(posedge i_clk) disable iff (!i_rstn)
    $fell(we_n) |-> !we_n [*6] ##1 we_n) else $error("strobe width wrong");
  a_unlock_first: assert property (@(posedge i_clk) disable iff (!i_rstn)
    ($fell(we_n) && step == 3'd0 && op != fcs_pkg::OP_RESET && !is_read)
    |-> dq == fcs_pkg::CMD_UNLOCK1 && fa == 17'h0_5555)
    else $error("first unlock cycle wrong");
  a_unlock_second: assert property (@(posedge i_clk) disable iff (!i_rstn)
    ($fell(we_n) && step == 3'd1) |-> dq == fcs_pkg::CMD_UNLOCK2 && fa == 17'h0_2AAA)
    else $error("second unlock cycle wrong");
  a_reset_code: assert property (@(posedge i_clk) disable iff (!i_rstn)
    ($fell(we_n) && op == fcs_pkg::OP_RESET) |-> dq == fcs_pkg::CMD_RESET)
    else $error("reset code wrong");
  a_sect_code: assert property (@(posedge i_clk) disable iff (!i_rstn)
    ($fell(we_n) && step == 3'd5 && (op == fcs_pkg::OP_SECT_ERS || op == fcs_pkg::OP_SECT_ADD))
    |-> dq == fcs_pkg::CMD_SECT_ERS && fa[13:0] == 14'h0000)
    else $error("sector erase cycle wrong");
  a_read_done: assert property (@(posedge i_clk) disable iff (!i_rstn)
    $fell(oe_n) |-> ##[1:13] done) else $error("read did not finish");
  c_program: cover property (@(posedge i_clk) disable iff (!i_rstn)
    done && op == fcs_pkg::OP_PROGRAM);
  c_sect_add: cover property (@(posedge i_clk) disable iff (!i_rstn)
    done && op == fcs_pkg::OP_SECT_ADD);
  c_read: cover property (@(posedge i_clk) disable iff (!i_rstn) done && is_read);
endmodule : fcs_host
`default_nettype wire

// ### tb/fcs_flash_model.sv
// Behavioural model of the byte-wide flash device behind the host
`default_nettype none
module fcs_flash_model #(
  parameter logic [7:0] MFR_CODE = 8'h3C,  // Arbitrary value
  parameter logic [7:0] DEV_CODE = 8'hC3,  // Arbitrary value
  parameter logic [7:0] PROT     = 8'h04,
  parameter real        BUSY_NS  = 2000.0  // Internal routine length, plain default
) (
  // Flash pins
  input  wire logic [16:0] i_fa,
  input  wire logic [7:0]  i_dq,
  input  wire logic        i_dq_oe,
  input  wire logic        i_ce_n,
  input  wire logic        i_we_n,
  input  wire logic        i_oe_n,
  output logic [7:0]       o_dq,
  output int               o_nwr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [0:131071];
  logic [16:0] la;
  logic        asel;
  logic        win;
  int          step;
  realtime     tw;
  realtime     bsy_end;
  logic [7:0]  val;

  initial begin
    foreach (mem[k]) mem[k] = 8'hFF;
    asel = 1'b0;
    win = 1'b0;
    step = 0;
    o_nwr = 0;
    bsy_end = 0.0;
  end

  // Sector or chip erase; preprogramming to zero is invisible so only the end state is kept
  task automatic ers(input logic [2:0] s, input logic all);
    foreach (mem[k]) if (all || k[16:14] == s) mem[k] = 8'hFF;
  endtask : ers

  task automatic wr(input logic [16:0] a, input logic [7:0] d);
    logic [14:0] lo;
    lo = a[14:0];
    o_nwr++;
    // Writes during a running routine are counted but have no effect
    if ($realtime < bsy_end) return;
    if (step == 9) begin
      mem[a] = mem[a] & d;
      bsy_end = $realtime + BUSY_NS;
      step = 0;
    end else if (d == 8'hF0) begin
      step = 0;
      asel = 1'b0;
      win = 1'b0;
    end else if (win && d == 8'h30 && ($realtime - tw) < 50000.0) begin
      ers(a[16:14], 1'b0);
      tw = $realtime;
    end else begin
      win = 1'b0;
      case (step)
        0: step = (lo == 15'h5555 && d == 8'hAA) ? 1 : 0;
        1: step = (lo == 15'h2AAA && d == 8'h55) ? 2 : 0;
        2: begin
          step = 0;
          if (lo == 15'h5555 && d == 8'h90) asel = 1'b1;
          if (lo == 15'h5555 && d == 8'hA0) step = 9;
          if (lo == 15'h5555 && d == 8'h80) step = 3;
        end
        3: step = (lo == 15'h5555 && d == 8'hAA) ? 4 : 0;
        4: step = (lo == 15'h2AAA && d == 8'h55) ? 5 : 0;
        default: begin
          step = 0;
          if (lo == 15'h5555 && d == 8'h10) begin
            ers(3'h0, 1'b1);
            bsy_end = $realtime + BUSY_NS;
          end
          if (d == 8'h30) begin
            ers(a[16:14], 1'b0);
            win = 1'b1;
            tw = $realtime;
          end
        end
      endcase
    end
  endtask : wr

  // Address at the later falling edge; chip select is already low here
  always @(negedge i_we_n or negedge i_ce_n) begin
    if (!i_ce_n && !i_we_n && i_oe_n) la = i_fa;
  end
  // Undriven data lines never make a valid write
  always @(posedge i_we_n) if (!i_ce_n && i_oe_n && !i_dq_oe) wr(la, i_dq);

  always @(i_fa, i_ce_n, i_oe_n, asel, o_nwr) begin
    // While busy the model shows the complement of the cell as its status
    if ($realtime < bsy_end) val = ~mem[i_fa];
    else if (!asel) val = mem[i_fa];
    else if (i_fa[7:0] == 8'h00) val = MFR_CODE;
    else if (i_fa[7:0] == 8'h01) val = DEV_CODE;
    else val = {7'h00, PROT[i_fa[16:14]]};
    // Released bus shows the inverse so a stale sample cannot pass
    o_dq = (!i_ce_n && !i_oe_n) ? val : ~val;
  end
endmodule : fcs_flash_model
`default_nettype wire

// ### tb/tb.sv
// Testbench for the flash host controller
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] MFR = 8'h3C;  // Arbitrary value
  localparam logic [7:0] DEV = 8'hC3;  // Arbitrary value
  logic        i_clk, i_rstn, i_req;
  logic [3:0]  i_op;
  logic [16:0] i_addr, o_fa;
  logic [7:0]  i_data, o_rdata, o_dq_out, dq_in;
  logic        o_busy, o_done, o_dq_oe, o_ce_n, o_we_n, o_oe_n;
  int          nwr, mismatches, n_compared;

  fcs_host i_fcs_host (.i_clk(i_clk), .i_rstn(i_rstn), .i_req(i_req), .i_op(i_op),
    .i_addr(i_addr), .i_data(i_data), .o_busy(o_busy), .o_done(o_done), .o_rdata(o_rdata),
    .o_fa(o_fa), .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe), .i_dq_in(dq_in), .o_ce_n(o_ce_n),
    .o_we_n(o_we_n), .o_oe_n(o_oe_n));
  fcs_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV), .PROT(8'h04)) i_fcs_flash_model (
    .i_fa(o_fa), .i_dq(o_dq_out), .i_dq_oe(o_dq_oe), .i_ce_n(o_ce_n), .i_we_n(o_we_n),
    .i_oe_n(o_oe_n), .o_dq(dq_in), .o_nwr(nwr));

  always #4 i_clk = ~i_clk;

  task automatic print_verdict;
    $display("mismatches=%0d n_compared=%0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t read %h expected %h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_cnt(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      mismatches++;
      $display("[ERR] %0t write strobes %0d expected %0d", $time, got, exp);
    end
  endtask : chk_cnt

  // Sector gap leaves busy low; a request there ends the gap and is taken one cycle later
  task automatic run(input logic [3:0] op, input logic [16:0] a, input logic [7:0] d,
                     input int nw);
    int w0, k;
    w0 = nwr;
    for (k = 0; k < 4000 && o_busy !== 1'b0; k++) @(negedge i_clk);
    if (k == 4000) begin
      mismatches++;
      $display("[ERR] %0t host stays busy", $time);
      print_verdict;
    end
    @(posedge i_clk);
    i_req <= 1'b1;
    i_op <= op;
    i_addr <= a;
    i_data <= d;
    for (k = 0; k < 4000 && o_busy !== 1'b1; k++) @(negedge i_clk);
    if (k == 4000) begin
      mismatches++;
      $display("[ERR] %0t request not taken", $time);
      print_verdict;
    end
    @(posedge i_clk);
    i_req <= 1'b0;
    for (k = 0; k < 200 && o_done !== 1'b1; k++) @(negedge i_clk);
    if (k == 200) begin
      mismatches++;
      $display("[ERR] %0t no completion", $time);
      print_verdict;
    end
    chk_cnt(nwr - w0, nw);
  endtask : run

  task automatic rd(input logic [16:0] a, input logic [7:0] e);
    run(fcs_pkg::OP_READ, a, 8'h00, 0);
    chk_byte(o_rdata, e);
  endtask : rd

  // The host does not poll, so the bench outwaits the internal routine
  task automatic settle;
    repeat (300) @(posedge i_clk);
  endtask : settle

  task automatic pgm(input logic [16:0] a, input logic [7:0] d);
    run(fcs_pkg::OP_PROGRAM, a, d, 4);
    settle;
  endtask : pgm

  task automatic t_autosel;
    run(fcs_pkg::OP_AUTOSEL, 17'h0_0000, 8'h00, 3);
    rd(17'h0_0000, MFR);
    rd(17'h1_C000, MFR);
    rd(17'h0_0001, DEV);
    rd(17'h0_8002, 8'h01);
    rd(17'h1_0002, 8'h00);
    run(fcs_pkg::OP_RESET, 17'h0_0000, 8'h00, 1);
    rd(17'h0_0001, 8'hFF);
  endtask : t_autosel

  task automatic t_program;
    pgm(17'h0_4010, 8'h5A);
    rd(17'h0_4010, 8'h5A);
    pgm(17'h0_4010, 8'hA5);
    rd(17'h0_4010, 8'h00);
    pgm(17'h1_C005, 8'h12);
    pgm(17'h0_8003, 8'h34);
  endtask : t_program

  // Second program lands while the first routine still runs
  task automatic t_busy;
    run(fcs_pkg::OP_PROGRAM, 17'h0_C020, 8'h3C, 4);
    run(fcs_pkg::OP_PROGRAM, 17'h0_C020, 8'h00, 4);
    rd(17'h0_C020, 8'hC3);
    settle;
    rd(17'h0_C020, 8'h3C);
  endtask : t_busy

  // Reset in mid sequence: pins go idle, the aborted write is never completed
  task automatic t_reset;
    int w0, k;
    w0 = nwr;
    @(posedge i_clk);
    i_req <= 1'b1;
    i_op <= fcs_pkg::OP_PROGRAM;
    i_addr <= 17'h0_C040;
    i_data <= 8'h77;
    @(posedge i_clk);
    @(posedge i_clk);
    i_req <= 1'b0;
    for (k = 0; k < 100 && nwr == w0; k++) @(negedge i_clk);
    if (k == 100) begin
      mismatches++;
      $display("[ERR] %0t first write missing", $time);
      print_verdict;
    end
    @(posedge i_clk);
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    chk_byte({3'b000, o_ce_n, o_we_n, o_oe_n, o_dq_oe, o_busy}, 8'h1E);
    chk_cnt(nwr - w0, 1);
    @(posedge i_clk);
    i_rstn <= 1'b1;
    run(fcs_pkg::OP_RESET, 17'h0_0000, 8'h00, 1);
    pgm(17'h0_C040, 8'h77);
    rd(17'h0_C040, 8'h77);
  endtask : t_reset

  task automatic t_erase;
    run(fcs_pkg::OP_SECT_ERS, 17'h0_4000, 8'h00, 6);
    run(fcs_pkg::OP_SECT_ADD, 17'h1_C000, 8'h00, 1);
    rd(17'h0_4010, 8'hFF);
    rd(17'h1_C005, 8'hFF);
    rd(17'h0_8003, 8'h34);
    run(fcs_pkg::OP_CHIP_ERS, 17'h0_0000, 8'h00, 6);
    settle;
    rd(17'h0_8003, 8'hFF);
  endtask : t_erase

  initial begin
    i_clk = 1'b0;
    i_rstn = 1'b0;
    i_req = 1'b0;
    i_op = 4'h0;
    i_addr = 17'h0_0000;
    i_data = 8'h00;
    mismatches = 0;
    n_compared = 0;
    repeat (20) @(posedge i_clk);
    i_rstn <= 1'b1;
    rd(17'h0_0123, 8'hFF);
    t_autosel;
    t_program;
    t_busy;
    t_erase;
    t_reset;
    print_verdict;
  end
endmodule : tb
`default_nettype wire
